// File: src/csf_core_sfr_file.v
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "csf_consts.vh"
module csf_core_sfr_file #(
   parameter ADDR_W = 10
) (
   input wire clk_sys,
   input wire resetn,
   input wire [ADDR_W-1:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire master_reset_pin_n,
   input wire wdt_reset,
   input wire core_wr,
   input wire [6:0] core_addr,
   input wire [7:0] core_wdata,
   input wire [2:0] core_op,
   input wire [7:0] core_opa,
   input wire [7:0] core_opb,
   input wire core_cin,
   input wire core_rd,
   input wire [6:0] core_rd_addr,
   output reg [7:0] core_rdata,
   input wire wdt_expired_evt,
   input wire sleep_evt,
   input wire wdt_clear_evt,
   input wire pc_load,
   input wire [12:0] pc_next,
   output reg [12:0] pc,
   output reg [7:0] option_bits,
   output reg [4:0] port_a_dir,
   output reg [7:0] port_b_dir,
   output reg [7:0] port_a_latch,
   output reg [7:0] port_b_latch,
   output reg bank_sel
);
   reg [7:0] timer_count;
   reg [7:0] status;
   reg [7:0] indirect_pointer;
   reg [7:0] nv_data_buffer;
   reg [7:0] nv_address;
   reg [4:0] pc_high_latch;
   reg [7:0] interrupt_control;
   reg [4:0] nv_control;
   reg [2:0] mr_sync;
   reg mr_state;
   reg warm_rst;
   reg warm_wdt;
   reg [7:0] next_status;
   wire bus_req;
   wire [7:0] bus_idx;
   wire bus_wr;
   wire wr_any;
   wire [7:0] wr_idx;
   wire [7:0] wr_val;
   wire [2:0] wr_op;
   wire [7:0] alu_res;
   wire alu_z;
   wire alu_dc;
   wire alu_c;
   wire [4:0] low_sum;
   wire [8:0] full_sum;
   wire [7:0] opb_eff;
   wire [7:0] core_rd_idx;
   wire we_timer;
   wire we_pcl;
   wire we_status;
   wire we_pointer;
   wire we_port_a_pins;
   wire we_port_b_pins;
   wire we_nvdata;
   wire we_nvaddr;
   wire we_pclatch;
   wire we_intctl;
   wire we_options;
   wire we_dira;
   wire we_dirb;
   wire we_nvctl;

   // Bank and window resolution to a physical index
   function [7:0] csf_resolve;
      input [6:0] addr;
      input bank;
      input [7:0] ptr;
      begin
         if (addr == 7'h00)
            csf_resolve = ptr;
         else
            csf_resolve = {bank, addr};
      end
   endfunction

   // Read decode shared by the bus and the core port
   function [7:0] csf_read;
      input [7:0] idx;
      begin
         csf_read = 8'h00;
         case (idx[6:0])
            7'h02: csf_read = pc[7:0];
            7'h03: csf_read = status;
            7'h04: csf_read = indirect_pointer;
            7'h0A: csf_read = {3'h0, pc_high_latch};
            7'h0B: csf_read = interrupt_control;
            default: begin
               // Window, unlock port and holes have no storage
               case (idx)
                  `CSF_IDX_TIMER: csf_read = timer_count;
                  `CSF_IDX_PORT_A_PINS: csf_read = {3'h0, port_a_latch[4:0]};
                  `CSF_IDX_PORT_B_PINS: csf_read = port_b_latch;
                  `CSF_IDX_NVDATA: csf_read = nv_data_buffer;
                  `CSF_IDX_NVADDR: csf_read = nv_address;
                  `CSF_IDX_OPTIONS: csf_read = option_bits;
                  `CSF_IDX_DIRA: csf_read = {3'h0, port_a_dir};
                  `CSF_IDX_DIRB: csf_read = port_b_dir;
                  `CSF_IDX_NVCTL: csf_read = {3'h0, nv_control};
                  `CSF_IDX_HOLE: csf_read = 8'h00;
                  `CSF_IDX_HOLE1: csf_read = 8'h00;
                  default: csf_read = 8'h00;
               endcase
            end
         endcase
      end
   endfunction

   // Write hit; shared registers answer in both banks
   function csf_hit;
      input [7:0] idx;
      input [7:0] reg_idx;
      input shared;
      begin
         if (shared)
            csf_hit = (idx[6:0] == reg_idx[6:0]);
         else
            csf_hit = (idx == reg_idx);
      end
   endfunction

   // Bus index is the register index, byte address is index times four
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_idx = wb_adr_i[9:2];
   assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
   // Core writes win over the bus in the same cycle
   assign wr_any = core_wr | bus_wr;
   assign wr_idx = core_wr ? csf_resolve(core_addr, status[`CSF_ST_BANK], indirect_pointer) : bus_idx;
   assign wr_val = core_wr ? core_wdata : wb_dat_i[7:0];
   assign wr_op = core_wr ? core_op : `CSF_OP_PLAIN;
   assign core_rd_idx = csf_resolve(core_rd_addr, status[`CSF_ST_BANK], indirect_pointer);

   // Per-register write strobes; holes match none
   assign we_timer = wr_any & csf_hit(wr_idx, `CSF_IDX_TIMER, 1'b0);
   assign we_pcl = wr_any & csf_hit(wr_idx, `CSF_IDX_PCL, 1'b1);
   assign we_status = wr_any & csf_hit(wr_idx, `CSF_IDX_STATUS, 1'b1);
   assign we_pointer = wr_any & csf_hit(wr_idx, `CSF_IDX_POINTER, 1'b1);
   assign we_port_a_pins = wr_any & csf_hit(wr_idx, `CSF_IDX_PORT_A_PINS, 1'b0);
   assign we_port_b_pins = wr_any & csf_hit(wr_idx, `CSF_IDX_PORT_B_PINS, 1'b0);
   assign we_nvdata = wr_any & csf_hit(wr_idx, `CSF_IDX_NVDATA, 1'b0);
   assign we_nvaddr = wr_any & csf_hit(wr_idx, `CSF_IDX_NVADDR, 1'b0);
   assign we_pclatch = wr_any & csf_hit(wr_idx, `CSF_IDX_PCLATCH, 1'b1);
   assign we_intctl = wr_any & csf_hit(wr_idx, `CSF_IDX_INTCTL, 1'b1);
   assign we_options = wr_any & csf_hit(wr_idx, `CSF_IDX_OPTIONS, 1'b0);
   assign we_dira = wr_any & csf_hit(wr_idx, `CSF_IDX_DIRA, 1'b0);
   assign we_dirb = wr_any & csf_hit(wr_idx, `CSF_IDX_DIRB, 1'b0);
   assign we_nvctl = wr_any & csf_hit(wr_idx, `CSF_IDX_NVCTL, 1'b0);

   // Flag arithmetic; subtraction adds the complement so carries become inverted borrows
   assign opb_eff = (core_op == `CSF_OP_SUB) ? ~core_opb : core_opb;
   assign low_sum = {1'b0, core_opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, (core_op == `CSF_OP_SUB) | core_cin};
   assign full_sum = {1'b0, core_opa} + {1'b0, opb_eff} + {8'h00, (core_op == `CSF_OP_SUB) | core_cin};
   assign alu_res = full_sum[7:0];
   assign alu_z = (core_op == `CSF_OP_LOGIC) ? (core_wdata == 8'h00) : (alu_res == 8'h00);
   assign alu_dc = low_sum[4];
   assign alu_c = full_sum[8];

   // Status next value: device events, instruction flags, then the write
   always @* begin
      next_status = status;
      if (wdt_expired_evt)
         next_status[`CSF_ST_WDT] = 1'b0;
      if (sleep_evt) begin
         next_status[`CSF_ST_SLEEP] = 1'b0;
         next_status[`CSF_ST_WDT] = 1'b1;
      end
      if (wdt_clear_evt) begin
         next_status[`CSF_ST_SLEEP] = 1'b1;
         next_status[`CSF_ST_WDT] = 1'b1;
      end
      if (core_wr && (core_op == `CSF_OP_ARITH || core_op == `CSF_OP_SUB)) begin
         next_status[`CSF_ST_C] = alu_c;
         next_status[`CSF_ST_DC] = alu_dc;
         next_status[`CSF_ST_ZERO] = alu_z;
      end else if (core_wr && core_op == `CSF_OP_LOGIC)
         next_status[`CSF_ST_ZERO] = alu_z;
      else if (core_wr && core_op == `CSF_OP_CLEAR)
         next_status[`CSF_ST_ZERO] = 1'b1;
      // Watchdog and sleep flags not writable
      if (we_status) begin
         next_status[7:5] = wr_val[7:5];
         if (wr_op == `CSF_OP_CLEAR)
            next_status[7:5] = 3'h0;
         if (wr_op == `CSF_OP_PLAIN)
            next_status[2:0] = wr_val[2:0];
      end
   end

   // Pin reset input, three-stage sample
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mr_sync <= 3'h7;
         mr_state <= 1'b1;
         warm_rst <= 1'b0;
         warm_wdt <= 1'b0;
      end else begin
         mr_sync <= {mr_sync[1:0], master_reset_pin_n};
         if (mr_sync[1] == mr_sync[2])
            mr_state <= mr_sync[2];
         warm_rst <= (~mr_state) | wdt_reset;
         warm_wdt <= wdt_reset;
      end
   end

   // Status, bank output and program counter
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         status <= `CSF_RST_STATUS;
         bank_sel <= 1'b0;
         pc <= 13'h0000;
         pc_high_latch <= 5'h00;
      end else if (warm_rst) begin
         // Watchdog and sleep flags kept on a pin reset, watchdog flag cleared by a watchdog reset
         status <= {3'h0, warm_wdt ? 1'b0 : status[`CSF_ST_WDT], status[3:0]};
         bank_sel <= 1'b0;
         pc <= 13'h0000;
         pc_high_latch <= 5'h00;
      end else begin
         status <= next_status;
         bank_sel <= next_status[`CSF_ST_BANK];
         if (we_pcl)
            pc <= {pc_high_latch, wr_val};
         else if (pc_load)
            pc <= pc_next;
         if (we_pclatch)
            pc_high_latch <= wr_val[4:0];
      end
   end

   // Port directions and options, all pins inputs after any reset
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         option_bits <= `CSF_RST_OPTIONS;
         port_a_dir <= 5'h1F;
         port_b_dir <= `CSF_RST_DIRB;
      end else if (warm_rst) begin
         option_bits <= `CSF_RST_OPTIONS;
         port_a_dir <= 5'h1F;
         port_b_dir <= `CSF_RST_DIRB;
      end else begin
         if (we_options)
            option_bits <= wr_val;
         if (we_dira)
            port_a_dir <= wr_val[4:0];
         if (we_dirb)
            port_b_dir <= wr_val;
      end
   end

   // Interrupt and nonvolatile control, partly kept over a warm reset
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         interrupt_control <= `CSF_RST_INTCTL;
         nv_control <= 5'h00;
      end else if (warm_rst) begin
         interrupt_control <= {7'h00, interrupt_control[0]};
         nv_control <= {nv_control[4], 4'h0};
      end else begin
         if (we_intctl)
            interrupt_control <= wr_val;
         if (we_nvctl)
            nv_control <= wr_val[4:0];
      end
   end

   // Data registers keep their contents over a warm reset
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         timer_count <= 8'h00;
         indirect_pointer <= 8'h00;
         nv_data_buffer <= 8'h00;
         nv_address <= 8'h00;
         port_a_latch <= 8'h00;
         port_b_latch <= 8'h00;
      end else if (!warm_rst) begin
         if (we_timer)
            timer_count <= wr_val;
         if (we_pointer)
            indirect_pointer <= wr_val;
         if (we_nvdata)
            nv_data_buffer <= wr_val;
         if (we_nvaddr)
            nv_address <= wr_val;
         if (we_port_a_pins)
            port_a_latch <= {3'h0, wr_val[4:0]};
         if (we_port_b_pins)
            port_b_latch <= wr_val;
      end
   end

   // Bus answer and read data launched together at the taking edge
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         core_rdata <= 8'h00;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req)
            wb_dat_o <= {24'h000000, csf_read(bus_idx)};
         if (core_rd)
            core_rdata <= csf_read(core_rd_idx);
      end
   end
endmodule // csf_core_sfr_file
`default_nettype wire

// File: pkg/csf_consts.vh
`ifndef CSF_CONSTS_VH
`define CSF_CONSTS_VH
// Register indices, byte address is four times the index
`define CSF_IDX_WINDOW 8'h00
`define CSF_IDX_TIMER 8'h01
`define CSF_IDX_PCL 8'h02
`define CSF_IDX_STATUS 8'h03
`define CSF_IDX_POINTER 8'h04
`define CSF_IDX_PORT_A_PINS 8'h05
`define CSF_IDX_PORT_B_PINS 8'h06
`define CSF_IDX_HOLE 8'h07
`define CSF_IDX_NVDATA 8'h08
`define CSF_IDX_NVADDR 8'h09
`define CSF_IDX_PCLATCH 8'h0A
`define CSF_IDX_INTCTL 8'h0B
`define CSF_IDX_OPTIONS 8'h81
`define CSF_IDX_DIRA 8'h85
`define CSF_IDX_DIRB 8'h86
`define CSF_IDX_HOLE1 8'h87
`define CSF_IDX_NVCTL 8'h88
`define CSF_IDX_NVUNLOCK 8'h89
// Status field positions
`define CSF_ST_BANK 5
`define CSF_ST_WDT 4
`define CSF_ST_SLEEP 3
`define CSF_ST_ZERO 2
`define CSF_ST_DC 1
`define CSF_ST_C 0
// Reset values
`define CSF_RST_STATUS 8'h18
`define CSF_RST_PCL 8'h00
`define CSF_RST_PCLATCH 8'h00
`define CSF_RST_OPTIONS 8'hFF
`define CSF_RST_DIRA 8'h1F
`define CSF_RST_DIRB 8'hFF
`define CSF_RST_INTCTL 8'h00
`define CSF_RST_NVCTL 8'h00
// Core write kinds
`define CSF_OP_PLAIN 3'h0
`define CSF_OP_CLEAR 3'h1
`define CSF_OP_ARITH 3'h2
`define CSF_OP_SUB 3'h3
`define CSF_OP_LOGIC 3'h4
`endif

// File: sim/csf_core_sfr_file_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module csf_sfr_chk (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic master_reset_pin_n,
   input wire logic wdt_reset,
   input wire logic pc_load,
   input wire logic [12:0] pc_next,
   input wire logic [12:0] pc,
   input wire logic [7:0] option_bits,
   input wire logic [4:0] port_a_dir,
   input wire logic [7:0] port_b_dir
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence pin_low_s;
      !master_reset_pin_n [*4];
   endsequence
   ack_resp_a: assert property (take_s |=> wb_ack_o)
      else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack unasked");
   dir_reset_a: assert property ($rose(resetn) |-> port_a_dir == 5'h1F && port_b_dir == 8'hFF)
      else $error("dir reset");
   opt_reset_a: assert property ($rose(resetn) |-> option_bits == 8'hFF)
      else $error("option reset");
   wdt_warm_a: assert property (wdt_reset |-> ##[1:6] port_a_dir == 5'h1F)
      else $error("watchdog reset");
   pin_warm_a: assert property (pin_low_s |-> ##[0:6] port_b_dir == 8'hFF)
      else $error("pin reset");
   pc_load_a: assert property (pc_load |=> pc == $past(pc_next))
      else $error("pc load");
endmodule // csf_sfr_chk
bind csf_core_sfr_file csf_sfr_chk i_chk (.*);
`default_nettype wire

// File: sim/csf_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module csf_core_model (
   input wire logic clk_sys,
   output logic core_wr,
   output logic [6:0] core_addr,
   output logic [7:0] core_wdata,
   output logic [2:0] core_op,
   output logic [7:0] core_opa,
   output logic [7:0] core_opb,
   output logic core_cin,
   output logic core_rd,
   output logic [6:0] core_rd_addr,
   output logic pc_load,
   output logic [12:0] pc_next
);
   initial begin
      {core_wr, core_rd, core_cin, pc_load} = 4'h0;
      {core_addr, core_rd_addr, core_op} = 17'h0;
      {core_wdata, core_opa, core_opb} = 24'h0;
      pc_next = 13'h0;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [2:0] o = 3'h0,
                     input logic [7:0] x = 8'h00, input logic [7:0] y = 8'h00);
      core_addr <= a;
      core_wdata <= d;
      core_op <= o;
      core_opa <= x;
      core_opb <= y;
      core_wr <= 1'b1;
      @(posedge clk_sys);
      core_wr <= 1'b0;
      core_wdata <= ~d;
      @(posedge clk_sys);
   endtask
   task automatic rdc(input logic [6:0] a);
      core_rd_addr <= a;
      core_rd <= 1'b1;
      @(posedge clk_sys);
      core_rd <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic ld(input logic [12:0] v);
      pc_next <= v;
      pc_load <= 1'b1;
      @(posedge clk_sys);
      pc_load <= 1'b0;
      @(posedge clk_sys);
   endtask
endmodule // csf_core_model
`default_nettype wire

// File: sim/csf_core_sfr_file_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin num_errors++; \
   $display("wrong value %s expected %h seen %h", n, e, v); end end
module csf_core_sfr_file_bench;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [9:0] wb_adr_i = 10'h000;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [3:0] wb_sel_i = 4'h1;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
   logic master_reset_pin_n = 1'b1, wdt_reset = 1'b0;
   logic wdt_expired_evt = 1'b0, sleep_evt = 1'b0, wdt_clear_evt = 1'b0;
   logic core_wr, core_rd, core_cin, pc_load, bank_sel;
   logic [2:0] core_op;
   logic [4:0] port_a_dir;
   logic [6:0] core_addr, core_rd_addr;
   logic [7:0] core_wdata, core_opa, core_opb, core_rdata, option_bits;
   logic [7:0] port_b_dir, port_a_latch, port_b_latch, q;
   logic [12:0] pc_next, pc;
   int num_errors = 0;
   int cmp_count = 0;
   csf_core_sfr_file i_csf_core_sfr_file (.*);
   csf_core_model i_csf_core_model (.*);
   always #4 clk_sys = ~clk_sys;
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {i, 2'h0};
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         num_errors++;
         results;
      end
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00);
      `CHK("read data", e, q)
   endtask
   task automatic t_reset;
      logic [15:0] t [7] = '{16'h0318, 16'h8318, 16'h81FF, 16'h851F, 16'h86FF, 16'h0A00, 16'h0B00};
      foreach (t[k])
         rd(t[k][15:8], t[k][7:0]);
      `CHK("dir b", 8'hFF, port_b_dir)
      $display("reset test done");
   endtask
   task automatic t_status;
      logic [39:0] t [7] = '{40'h0000000018, 40'h270000003F, 40'h000100001F, 40'h00020F011A,
                             40'h0003100119, 40'h0003010218, 40'h000305051F};
      foreach (t[k]) begin
         i_csf_core_model.wr(7'h03, t[k][39:32], t[k][26:24], t[k][23:16], t[k][15:8]);
         rd(8'h03, t[k][7:0]);
      end
      $display("status test done");
   endtask
   task automatic t_events;
      i_csf_core_model.wr(7'h03, 8'h20);
      sleep_evt <= 1'b1;
      @(posedge clk_sys);
      sleep_evt <= 1'b0;
      wdt_expired_evt <= 1'b1;
      @(posedge clk_sys);
      wdt_expired_evt <= 1'b0;
      bus(1'b1, 8'h86, 8'h00);
      rd(8'h03, 8'h20);
      master_reset_pin_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      master_reset_pin_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd(8'h03, 8'h00);
      `CHK("dir b", 8'hFF, port_b_dir)
      bus(1'b1, 8'h85, 8'h00);
      wdt_clear_evt <= 1'b1;
      @(posedge clk_sys);
      wdt_clear_evt <= 1'b0;
      wdt_reset <= 1'b1;
      @(posedge clk_sys);
      wdt_reset <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(8'h03, 8'h08);
      `CHK("dir a", 5'h1F, port_a_dir)
      $display("reset source test done");
   endtask
   task automatic t_map;
      bus(1'b1, 8'h04, 8'h85);
      i_csf_core_model.wr(7'h00, 8'h03);
      `CHK("window", 5'h03, port_a_dir)
      i_csf_core_model.wr(7'h03, 8'h20);
      `CHK("bank", 1'b1, bank_sel)
      i_csf_core_model.wr(7'h05, 8'h0A);
      `CHK("dir a", 5'h0A, port_a_dir)
      i_csf_core_model.rdc(7'h00);
      `CHK("window read", 8'h0A, core_rdata)
      i_csf_core_model.wr(7'h03, 8'h00);
      i_csf_core_model.wr(7'h05, 8'h55);
      `CHK("latch a", 8'h15, port_a_latch)
      bus(1'b1, 8'h06, 8'hA5);
      `CHK("latch b", 8'hA5, port_b_latch)
      bus(1'b1, 8'h8A, 8'h15);
      rd(8'h0A, 8'h15);
      i_csf_core_model.wr(7'h02, 8'h34);
      `CHK("pc", 13'h1534, pc)
      i_csf_core_model.ld(13'h0ABC);
      rd(8'h0A, 8'h15);
      rd(8'h02, 8'hBC);
      bus(1'b1, 8'h07, 8'hFF);
      bus(1'b1, 8'h87, 8'hFF);
      rd(8'h07, 8'h00);
      rd(8'h87, 8'h00);
      $display("map test done");
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      t_reset;
      t_status;
      t_events;
      t_map;
      results;
   end
endmodule // csf_core_sfr_file_bench
`default_nettype wire
